// File: dv/wms_primary_model.sv
/*
 behavioural primary-side controller as seen through the transformer winding.
 assumes the bench calls its tasks; it drives at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module wms_primary_model (
    input wire logic clk_i, // core clock
    input wire logic wake_drive_i, // wake current pulse from the device
    output logic wake_low_o // winding below detect threshold
);
    localparam int MAX_GAP = 8_000_000; // 40 ms at 200 MHz

    // winding sits above threshold between power cycles
    initial wake_low_o = 1'b0;

    // one power cycle: winding low, then back above threshold
    task automatic power_cycle(input int low_cyc, input int high_cyc);
        int hold;
        hold = (high_cyc > MAX_GAP) ? MAX_GAP : high_cyc;
        wake_low_o = 1'b1;
        repeat (low_cyc) @(negedge clk_i);
        wake_low_o = 1'b0;
        repeat (hold) @(negedge clk_i);
    endtask

    // answer a wake pulse after it ends; bounded so a dead device cannot hang us
    task automatic answer_wake(input int delay_cyc);
        int n;
        for (n = 0; n < 2000 && wake_drive_i !== 1'b1; n++) @(negedge clk_i);
        for (n = 0; n < 2000 && wake_drive_i !== 1'b0; n++) @(negedge clk_i);
        repeat (delay_cyc) @(negedge clk_i);
        power_cycle(110, 20);
    endtask
endmodule
`default_nettype wire

// File: dv/wms_top_test.sv
/*
 self-checking bench for the wake monitor sequencer.
 assumes shortened period thresholds; arming time stays at its real 100 cycles.
*/
`timescale 1ns/1ps
`include "wms_defines.svh"
`default_nettype none
module wms_top_test;
    localparam int REPEAT = 600;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [`WMS_SAMPLE_W-1:0] supply_i = 12'h03e8;
    logic test_neg_i = 1'b0;
    wire logic wake_low_i;
    logic wake_drive_o, wake_oe_o, secondary_enable_out_o, secondary_enable_oe_o;
    logic power_cycle_detect_o, test_mode_o;
    logic [`WMS_DETECT_CNT_W-1:0] detect_count_o;
    logic [`WMS_SAMPLE_W-1:0] sample_o;
    int bad_count = 0;
    int n_compared = 0;
    int pulses = 0;

    // periods shortened so both period thresholds sit above the arming time
    wms_top #(.DISABLE_CYC(300), .ENABLE_CYC(200), .REPEAT_CYC(REPEAT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wake_low_i(wake_low_i), .supply_i(supply_i),
        .test_neg_i(test_neg_i), .wake_drive_o(wake_drive_o), .wake_oe_o(wake_oe_o),
        .secondary_enable_out_o(secondary_enable_out_o),
        .secondary_enable_oe_o(secondary_enable_oe_o),
        .power_cycle_detect_o(power_cycle_detect_o), .detect_count_o(detect_count_o),
        .sample_o(sample_o), .test_mode_o(test_mode_o));
    wms_primary_model i_partner (.clk_i(clk_i), .wake_drive_i(wake_drive_o), .wake_low_o(wake_low_i));

    // clock and detect pulse tally
    always #2.5 clk_i = ~clk_i;
    always @(negedge clk_i) if (power_cycle_detect_o === 1'b1) pulses <= pulses + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic t_arm();
        int p0;
        logic [15:0] c0;
        p0 = pulses;
        c0 = detect_count_o;
        check(16'(secondary_enable_oe_o), 16'h0000);
        i_partner.power_cycle(90, 20);
        check(16'(pulses - p0), 16'h0000);
        i_partner.power_cycle(110, 20);
        check(16'(pulses - p0), 16'h0001);
        check(detect_count_o, c0 + 16'h0001);
        check(16'(sample_o), 16'h03e8);
    endtask

    task automatic t_droop();
        int n;
        int hi;
        supply_i = 12'h03cb; // one code above the trip point
        cyc(20);
        check(16'(wake_oe_o), 16'h0000);
        supply_i = 12'h03ca;
        for (n = 0; n < 8 && wake_oe_o !== 1'b1; n++) cyc(1);
        check(16'(wake_oe_o), 16'h0001);
        for (n = 0; n < 300 && wake_drive_o === 1'b1; n++) cyc(1);
        check(16'(n), 16'h00c8);
        for (n = 0; n < 900 && wake_drive_o !== 1'b1; n++) cyc(1);
        check(16'(n + 200), 16'(REPEAT));
        i_partner.answer_wake(5);
        hi = 0;
        for (n = 0; n < 1300; n++) begin
            cyc(1);
            if (wake_drive_o !== 1'b0) hi++;
        end
        check(16'(hi), 16'h0000);
        supply_i = 12'h03e8;
    endtask

    task automatic t_test();
        test_neg_i = 1'b1;
        cyc(1);
        check(16'(test_mode_o), 16'h0000);
        cyc(5);
        check(16'(test_mode_o), 16'h0001);
        supply_i = 12'h0300; // deep droop ignored while in test
        cyc(40);
        check(16'(wake_oe_o), 16'h0000);
        supply_i = 12'h03e8;
        cyc(5);
        test_neg_i = 1'b0;
        cyc(6);
        check(16'(test_mode_o), 16'h0000);
    endtask

    // each detect closes the period begun at the previous rise: high time before plus low time
    task automatic t_sec();
        int k;
        i_partner.power_cycle(110, 20);
        for (k = 0; k < 62; k++) i_partner.power_cycle(110, 200);
        check(16'(secondary_enable_oe_o), 16'h0000);
        i_partner.power_cycle(110, 20);
        // 62 long periods, then a short one restarts the tally; 63 long ones follow
        for (k = 0; k < 64; k++) begin
            i_partner.power_cycle(110, 200);
            if (k == 0) check(16'(secondary_enable_oe_o), 16'h0000);
            if (k == 62) check(16'(secondary_enable_oe_o), 16'h0000);
        end
        check(16'(secondary_enable_oe_o), 16'h0001);
        check(16'(secondary_enable_out_o), 16'h0000);
        // first detect still closes a long period, then 30 short ones
        for (k = 0; k < 31; k++) i_partner.power_cycle(110, 20);
        i_partner.power_cycle(110, 200); // short period 31
        check(16'(secondary_enable_oe_o), 16'h0001);
        i_partner.power_cycle(110, 20); // long period keeps the short tally
        check(16'(secondary_enable_oe_o), 16'h0001);
        i_partner.power_cycle(110, 20); // short period 32
        check(16'(secondary_enable_oe_o), 16'h0000);
    endtask

    task automatic t_lockout();
        int p0;
        p0 = pulses;
        rst_i = 1'b1;
        i_partner.power_cycle(110, 20);
        check(16'(pulses - p0), 16'h0000);
        check(detect_count_o, 16'h0000);
        check(16'(sample_o), 16'h0000);
        rst_i = 1'b0;
        cyc(1);
    endtask

    task automatic results();
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        cyc(2);
        rst_i = 1'b0;
        t_arm();
        t_droop();
        t_test();
        t_sec();
        t_lockout();
        results();
    end

    // watchdog at 80k cycles, well beyond the ~47k cycles the tests need
    initial begin
        #400_000;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire

// File: rtl/wms_defines.svh
/*
 timing constants and widths for the wake monitor sequencer.
 assumes a 200 MHz core clock (5 ns period).
*/
`ifndef WMS_DEFINES_SVH
`define WMS_DEFINES_SVH
`define WMS_CLK_PERIOD_PS 5000
`define WMS_ARM_TIME_NS 500
`define WMS_ARM_CYC ((`WMS_ARM_TIME_NS * 1000 + `WMS_CLK_PERIOD_PS - 1) / `WMS_CLK_PERIOD_PS)
`define WMS_DISABLE_TIME_US 177
`define WMS_DISABLE_CYC ((`WMS_DISABLE_TIME_US * 1000000 + `WMS_CLK_PERIOD_PS - 1) / `WMS_CLK_PERIOD_PS)
`define WMS_ENABLE_TIME_US 57
`define WMS_ENABLE_CYC ((`WMS_ENABLE_TIME_US * 1000000) / `WMS_CLK_PERIOD_PS)
`define WMS_LONG_COUNT 63
`define WMS_SHORT_COUNT 32
`define WMS_PULSE_TIME_NS 1000
`define WMS_PULSE_CYC ((`WMS_PULSE_TIME_NS * 1000) / `WMS_CLK_PERIOD_PS)
`define WMS_REPEAT_HZ 33000
`define WMS_REPEAT_CYC ((1000000000 / `WMS_REPEAT_HZ) * 1000 / `WMS_CLK_PERIOD_PS)
`define WMS_SAMPLE_W 12
`define WMS_DETECT_CNT_W 16
`define WMS_DROOP_NUM 97
`define WMS_DROOP_DEN 100
`endif

// File: rtl/wms_period_counter.sv
/*
 saturating cycle counter with a threshold compare.
 assumes clear comes from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wms_period_counter #(
    parameter int W = 20,
    parameter logic [W-1:0] LIMIT = '1
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic clear_i, // restart count
    output logic reached_o // count at or beyond limit
);
    logic [W-1:0] cnt_r;

    // saturation keeps a very long gap from wrapping into a short one
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt_r <= '0;
        end else if (cnt_r != '1) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign reached_o = (cnt_r >= LIMIT);
endmodule
`default_nettype wire

// File: rtl/wms_pkg.sv
/*
 types shared by the wake monitor sequencer.
 assumes nothing beyond a sv compiler.
*/
package wms_pkg;
    typedef enum logic [1:0] {
        WMS_LISTEN = 2'b00, // wake line as input
        WMS_PULSE = 2'b01, // driving a wake pulse
        WMS_GAP = 2'b10 // waiting between pulses
    } wms_wake_e;
endpackage

// File: rtl/wms_top.sv
/*
 wake monitor sequencer: power cycle detect, droop-triggered wake pulses,
 secondary enable from switching period counts.
 assumes rst_i is the undervoltage lockout, wake_low_i, droop inputs and
 test_neg_i come from analog comparators and an adc outside this clock domain.
*/
// Operation
// [RL1] enable output released while switching is frequent
// [RL2] pull enable low after 63 consecutive periods above disable threshold
// [RL3] release enable after 32 cumulative periods below enable threshold
// [RL4] arm detect only after wake line low beyond 500 ns
// [RL5] armed rising edge gives one detect pulse: osc reset, count, sample
// [RL6] enter wake output mode when supply reaches 97 percent of sample
// [RL7] drive 1 us pulses at 33 kHz until a power cycle is detected
// [RL8] negative voltage on enable pin enters test mode
// [RL9] partner keeps detected cycles no more than 40 ms apart
// [RL10] everything idle while undervoltage lockout holds
// [RL11] period is detect-to-detect; short period restarts long count
`timescale 1ns/1ps
`include "wms_defines.svh"
`default_nettype none
module wms_top #(
    parameter int LONG_COUNT = `WMS_LONG_COUNT,
    parameter int SHORT_COUNT = `WMS_SHORT_COUNT,
    parameter int DISABLE_CYC = `WMS_DISABLE_CYC,
    parameter int ENABLE_CYC = `WMS_ENABLE_CYC,
    parameter int REPEAT_CYC = `WMS_REPEAT_CYC
) (
    input wire logic clk_i, // internal oscillator
    input wire logic rst_i, // undervoltage lockout, high
    input wire logic wake_low_i, // wake line below detect threshold
    input wire logic [`WMS_SAMPLE_W-1:0] supply_i, // supply level code
    input wire logic test_neg_i, // enable pin below ground
    output logic wake_drive_o, // wake current switch on
    output logic wake_oe_o, // wake line in output mode
    output logic secondary_enable_out_o, // enable pin level (always 0)
    output logic secondary_enable_oe_o, // enable pin pulled low
    output logic power_cycle_detect_o, // one-cycle detect pulse
    output logic [`WMS_DETECT_CNT_W-1:0] detect_count_o, // detect counter
    output logic [`WMS_SAMPLE_W-1:0] sample_o, // stored supply sample
    output logic test_mode_o // manufacturing test mode
);
    localparam int ARM_CYC = `WMS_ARM_CYC;
    localparam int PULSE_CYC = `WMS_PULSE_CYC;

    logic wl_s1_r, wl_s2_r, tn_s1_r, tn_s2_r;
    logic [`WMS_SAMPLE_W-1:0] sup_s1_r, sup_s2_r;
    logic [7:0] low_cnt_r;
    logic armed_r, detect_r;
    logic [`WMS_DETECT_CNT_W-1:0] detect_cnt_r;
    logic [`WMS_SAMPLE_W-1:0] sample_r;
    logic sample_valid_r;
    logic droop;
    wms_pkg::wms_wake_e wake_st_r;
    logic [15:0] osc_cnt_r;
    logic long_seen, short_seen;
    logic [6:0] long_cnt_r;
    logic [5:0] short_cnt_r;
    logic sec_low_r;
    logic test_r;

    // two-stage synchronisers on analog comparator and adc inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wl_s1_r <= 1'b0;
            wl_s2_r <= 1'b0;
            tn_s1_r <= 1'b0;
            tn_s2_r <= 1'b0;
            sup_s1_r <= '0;
            sup_s2_r <= '0;
        end else begin
            wl_s1_r <= wake_low_i;
            wl_s2_r <= wl_s1_r;
            tn_s1_r <= test_neg_i;
            tn_s2_r <= tn_s1_r;
            sup_s1_r <= supply_i;
            sup_s2_r <= sup_s1_r;
        end
    end

    // low-time qualifier; ignored while we drive the line ourselves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_r <= '0;
            armed_r <= 1'b0;
        end else if (!wl_s2_r || wake_oe_o) begin
            low_cnt_r <= '0;
            if (!wl_s2_r && armed_r) begin
                armed_r <= 1'b0; // RL5
            end
        end else begin
            if (low_cnt_r < 8'(ARM_CYC)) begin
                low_cnt_r <= low_cnt_r + 8'h01;
            end else begin
                armed_r <= 1'b1; // RL4
            end
        end
    end

    // detect pulse on rising edge while armed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detect_r <= 1'b0;
        end else begin
            detect_r <= armed_r && !wl_s2_r; // RL5
        end
    end

    // detect counter and supply sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detect_cnt_r <= '0;
            sample_r <= '0;
            sample_valid_r <= 1'b0;
        end else if (detect_r) begin
            detect_cnt_r <= detect_cnt_r + 1'b1; // RL5
            sample_r <= sup_s2_r; // RL5
            sample_valid_r <= 1'b1;
        end
    end

    // droop compare; the 40 ms spacing keeps the sample fresh [RL9]
    assign droop = sample_valid_r && !test_r &&
        (32'(sup_s2_r) * `WMS_DROOP_DEN <= 32'(sample_r) * `WMS_DROOP_NUM); // RL6

    // oscillator phase counter, reset by each detect pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || detect_r) begin
            osc_cnt_r <= '0; // RL5
        end else if (wake_st_r == wms_pkg::WMS_LISTEN) begin
            osc_cnt_r <= '0;
        end else if (osc_cnt_r >= 16'(REPEAT_CYC - 1)) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    // wake output sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_st_r <= wms_pkg::WMS_LISTEN; // RL10
        end else if (detect_r) begin
            wake_st_r <= wms_pkg::WMS_LISTEN; // RL7
        end else begin
            case (wake_st_r)
                wms_pkg::WMS_LISTEN: begin
                    if (droop) begin
                        wake_st_r <= wms_pkg::WMS_PULSE; // RL6
                    end
                end
                wms_pkg::WMS_PULSE: begin
                    if (osc_cnt_r >= 16'(PULSE_CYC - 1)) begin
                        wake_st_r <= wms_pkg::WMS_GAP; // RL7
                    end
                end
                wms_pkg::WMS_GAP: begin
                    if (osc_cnt_r >= 16'(REPEAT_CYC - 1)) begin
                        wake_st_r <= wms_pkg::WMS_PULSE; // RL7
                    end
                end
                default: begin
                    wake_st_r <= wms_pkg::WMS_LISTEN;
                end
            endcase
        end
    end

    // the pin listens for power cycles in WMS_LISTEN and between pulses; it drives only in WMS_PULSE
    assign wake_oe_o = (wake_st_r == wms_pkg::WMS_PULSE);
    assign wake_drive_o = wake_oe_o;

    // switching period timers, detect to detect
    wms_period_counter #(.W(20), .LIMIT(20'(DISABLE_CYC))) u_disable (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(detect_r), // RL11
        .reached_o(long_seen)
    );
    // limit one below the threshold: a period of exactly the threshold is not short
    wms_period_counter #(.W(20), .LIMIT(20'(ENABLE_CYC - 1))) u_enable (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(detect_r),
        .reached_o(short_seen)
    );

    // enable output counts; periods judged at each detect pulse outside test mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            long_cnt_r <= '0;
            short_cnt_r <= '0;
            sec_low_r <= 1'b0; // RL1
        end else if (detect_r && !test_r) begin
            if (long_seen) begin
                long_cnt_r <= (long_cnt_r < 7'(LONG_COUNT)) ? long_cnt_r + 7'h01 : long_cnt_r;
                if (long_cnt_r + 7'h01 >= 7'(LONG_COUNT)) begin
                    sec_low_r <= 1'b1; // RL2
                    short_cnt_r <= '0;
                end
            end else begin
                long_cnt_r <= '0; // RL11
            end
            if (!short_seen && sec_low_r) begin
                if (short_cnt_r + 6'h01 >= 6'(SHORT_COUNT)) begin
                    sec_low_r <= 1'b0; // RL3
                    short_cnt_r <= '0;
                end else begin
                    short_cnt_r <= short_cnt_r + 6'h01; // RL3
                end
            end
        end
    end

    // test mode follows the enable pin polarity sense
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_r <= 1'b0;
        end else begin
            test_r <= tn_s2_r; // RL8
        end
    end

    assign secondary_enable_out_o = 1'b0;
    assign secondary_enable_oe_o = sec_low_r;
    assign power_cycle_detect_o = detect_r;
    assign detect_count_o = detect_cnt_r;
    assign sample_o = sample_r;
    assign test_mode_o = test_r;

    // checks
    a_pulse_single: assert property (@(posedge clk_i) disable iff (rst_i)
        detect_r |=> !detect_r) else $error("detect pulse longer than one cycle"); // RL5
    a_pulse_count: assert property (@(posedge clk_i) disable iff (rst_i)
        detect_r |=> detect_cnt_r == $past(detect_cnt_r) + 1'b1) else $error("detect count not advanced"); // RL5
    a_arm_needs_low: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(armed_r) |-> $past(wl_s2_r, 1) && low_cnt_r >= 8'(ARM_CYC)) else $error("armed too early"); // RL4
    a_droop_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
        (wake_st_r == wms_pkg::WMS_LISTEN && droop && !detect_r) |=> wake_oe_o) else $error("droop ignored"); // RL6
    a_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wake_oe_o) && osc_cnt_r == 16'h0000 |-> wake_oe_o [*2]) else $error("wake pulse too short"); // RL7
    a_stop_on_pcd: assert property (@(posedge clk_i) disable iff (rst_i)
        detect_r |=> wake_st_r == wms_pkg::WMS_LISTEN) else $error("wake repeat not stopped"); // RL7
    a_sec_release: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(sec_low_r) |-> $past(short_cnt_r) == 6'(SHORT_COUNT - 1)) else $error("enable released early"); // RL3
    a_sec_pull: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sec_low_r) |-> $past(long_cnt_r) >= 7'(LONG_COUNT - 1)) else $error("enable pulled early"); // RL2
    a_test_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        tn_s2_r |=> test_r) else $error("test mode missed"); // RL8
    c_detect: cover property (@(posedge clk_i) disable iff (rst_i) detect_r);
    c_wake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wake_oe_o));
    c_sec_low: cover property (@(posedge clk_i) disable iff (rst_i) $rose(sec_low_r));
    c_sec_rel: cover property (@(posedge clk_i) disable iff (rst_i) $fell(sec_low_r));
endmodule
`default_nettype wire
